// [core/cms_pkg.sv]
// Purpose: Shared constants for the counter mode sequencer
// Assumes: One counter channel, 16-bit count, gate and source from pins
// Notes: Gate control field decode lives here so both files agree
`default_nettype none
package cms_pkg;

    // ==========================================================
    // Widths
    // ==========================================================
    localparam int CMS_CNT_W = 16;           // Count, Load and Hold width
    localparam int CMS_GATE_W = 4;           // Gate control field width

    // ==========================================================
    // Counter values
    // ==========================================================
    localparam logic [CMS_CNT_W-1:0] CMS_TC_VALUE = 16'h0001;  // Terminal count value
    localparam logic [CMS_CNT_W-1:0] CMS_CNT_RESET = 16'h0000; // Count after reset
    localparam logic [CMS_CNT_W-1:0] CMS_CNT_STEP = 16'h0001;  // Decrement per edge

    // ==========================================================
    // Gate control field codes
    // ==========================================================
    localparam logic [CMS_GATE_W-1:0] CMS_GATE_NONE_CODE = 4'h0; // No gate control
    localparam int CMS_GATE_EDGE_BIT = 3;    // Set: edge gate, clear: level gate

    // Gate qualification type
    typedef enum logic [1:0] {
        CMS_GATE_NONE = 2'b00,
        CMS_GATE_LEVEL = 2'b01,
        CMS_GATE_EDGE = 2'b10
    } cms_gate_type;

    // Decode the gate control field into a qualification type
    function automatic cms_gate_type cms_gate_decode(input logic [CMS_GATE_W-1:0] field);
        cms_gate_type kind;
        kind = CMS_GATE_NONE;
        if (field == CMS_GATE_NONE_CODE) begin
            kind = CMS_GATE_NONE;
        end else if (field[CMS_GATE_EDGE_BIT]) begin
            kind = CMS_GATE_EDGE;
        end else begin
            kind = CMS_GATE_LEVEL;
        end
        return kind;
    endfunction : cms_gate_decode

endpackage : cms_pkg
`default_nettype wire

// [core/cms_edge_sync.sv]
// Purpose: Two-flop pin synchroniser with rising and falling edge pulses
// Assumes: Input is asynchronous to clk and slower than clk / 2
// Notes: First flop feeds only the second flop
`timescale 1ns/1ps
`default_nettype none
module cms_edge_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin side
    input wire logic pin_in,
    // Synchronised side
    output logic level_out,
    output logic rise_out,
    output logic fall_out
);

    // ==========================================================
    // Synchroniser chain
    // ==========================================================
    logic meta_ff;   // First stage, read only by sync_ff
    logic sync_ff;   // Second stage, safe level
    logic prev_ff;   // Delayed level for edge detection

    // Two-flop chain then one history flop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    // Edge pulses last one clock
    assign level_out = sync_ff;
    assign rise_out = sync_ff & ~prev_ff;
    assign fall_out = ~sync_ff & prev_ff;

endmodule : cms_edge_sync
`default_nettype wire

// [core/cms_sequencer.sv]
// Purpose: Mode sequencer for one counter/timer channel
// Assumes: Source and gate are active-high pins; host commands are clk pulses
// Notes: Counts down; terminal count is the state where count equals one
`timescale 1ns/1ps
`default_nettype none
module cms_sequencer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Counter pins
    input wire logic source_in,
    input wire logic gate_in,
    // Mode configuration
    input wire logic [cms_pkg::CMS_GATE_W-1:0] gate_control_field,
    input wire logic special_gate_bit,
    input wire logic reload_source_bit,
    input wire logic repetition_bit,
    input wire logic toggle_out_sel,
    // Reload values
    input wire logic [cms_pkg::CMS_CNT_W-1:0] load_value,
    input wire logic [cms_pkg::CMS_CNT_W-1:0] hold_value,
    // Host commands
    input wire logic arm_cmd,
    input wire logic disarm_cmd,
    input wire logic load_cmd,
    // Status and outputs
    output logic armed,
    output logic running,
    output logic [cms_pkg::CMS_CNT_W-1:0] count_value,
    output logic terminal_count,
    output logic tc_toggled,
    output logic counter_out
);
    import cms_pkg::*;

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic src_rise;    // Active-going source edge
    logic gate_lvl;    // Synchronised gate level
    logic gate_rise;   // Active-going gate edge
    logic gate_fall;   // Inactive-going gate edge
    logic src_lvl_unused;
    logic src_fall_unused;

    // Source pin: only the rising edge is used
    cms_edge_sync u_src_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(source_in),
        .level_out(src_lvl_unused),
        .rise_out(src_rise),
        .fall_out(src_fall_unused)
    );

    // Gate pin: level and both edges are used
    cms_edge_sync u_gate_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in(gate_in),
        .level_out(gate_lvl),
        .rise_out(gate_rise),
        .fall_out(gate_fall)
    );

    // ==========================================================
    // State
    // ==========================================================
    logic armed_ff;                       // Counter armed
    logic run_ff;                         // Edge-gated trigger seen
    logic phase_ff;                       // Set: next reload is the second of a pair
    logic tc_ff;                          // Count sits at terminal count
    logic toggle_ff;                      // Inverts on every terminal count
    logic [CMS_CNT_W-1:0] count_ff;       // Current count
    logic [CMS_CNT_W-1:0] nxt_count;      // Next count

    // ==========================================================
    // Mode decode
    // ==========================================================
    cms_gate_type gate_kind;              // Qualification type
    logic qualify;                        // Count allowed outside terminal count
    logic count_en;                       // This source edge is counted
    logic tc_exit;                        // Source edge that leaves terminal count
    logic cycle_done;                     // Exit that ends a whole count cycle
    logic auto_disarm;                    // Exit that disarms the counter
    logic [CMS_CNT_W-1:0] reload_val;     // Register chosen for this reload

    // The special gate bit only changes edge modes
    assign gate_kind = cms_gate_decode(gate_control_field);

    // Qualification per gate type
    always_comb begin
        qualify = 1'b0;
        unique case (gate_kind)
            CMS_GATE_NONE: begin
                // Gate input plays no part
                qualify = armed_ff;
            end
            CMS_GATE_LEVEL: begin
                // Edges while gate low are dropped
                qualify = armed_ff & gate_lvl;
            end
            CMS_GATE_EDGE: begin
                // Counting only after a trigger edge
                qualify = armed_ff & run_ff;
            end
            default: begin
                // Code 2'b11 never decoded
                qualify = 1'b0;
            end
        endcase
    end

    // Terminal count always takes the next source edge
    assign count_en = src_rise & (tc_ff | qualify);
    assign tc_exit = src_rise & tc_ff;

    // Alternating mode finishes its cycle on the second exit
    assign cycle_done = tc_exit & (~reload_source_bit | phase_ff);

    // Single-cycle modes disarm when the cycle ends
    assign auto_disarm = cycle_done & ~repetition_bit;

    // Hold on the first exit of a pair, Load otherwise
    assign reload_val = (reload_source_bit && !phase_ff) ? hold_value : load_value;

    // ==========================================================
    // Next count
    // ==========================================================
    always_comb begin
        nxt_count = count_ff;
        if (load_cmd) begin
            // Host load command
            nxt_count = load_value;
        end else if (tc_exit) begin
            // Reload on leaving terminal count
            nxt_count = reload_val;
        end else if (count_en) begin
            // Ordinary decrement
            nxt_count = count_ff - CMS_CNT_STEP;
        end
    end

    // Count register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_ff <= CMS_CNT_RESET;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // Terminal count flag, registered from the next count
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tc_ff <= 1'b0;
        end else begin
            tc_ff <= (nxt_count == CMS_TC_VALUE);
        end
    end

    // ==========================================================
    // Reload phase
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_ff <= 1'b0;
        end else if (load_cmd || !reload_source_bit) begin
            // Fresh load restarts the pair with Hold
            phase_ff <= 1'b0;
        end else if (tc_exit) begin
            // Alternate on each exit
            phase_ff <= ~phase_ff;
        end
    end

    // ==========================================================
    // Arm state
    // ==========================================================
    // Arm command wins over an automatic disarm in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            armed_ff <= 1'b0;
        end else if (arm_cmd) begin
            // Host arm
            armed_ff <= 1'b1;
        end else if (disarm_cmd) begin
            // Host disarm
            armed_ff <= 1'b0;
        end else if (auto_disarm) begin
            // Disarm only after the exit edge
            armed_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Edge-gated trigger state
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_ff <= 1'b0;
        end else if (gate_kind != CMS_GATE_EDGE || disarm_cmd) begin
            // Only edge modes use the trigger
            run_ff <= 1'b0;
        end else if (!run_ff) begin
            // Disarmed counters drop gate edges
            run_ff <= gate_rise & armed_ff;
        end else if (cycle_done) begin
            // Stop and wait for a new gate edge
            run_ff <= 1'b0;
        end else if (special_gate_bit && gate_fall) begin
            // Upper edge modes stop on gate fall
            run_ff <= 1'b0;
        end
        // Otherwise the gate is ignored while running
    end

    // ==========================================================
    // Toggled output
    // ==========================================================
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            toggle_ff <= 1'b0;
        end else if (tc_exit) begin
            // Inverts once per terminal count
            toggle_ff <= ~toggle_ff;
        end
    end

    // Output select register
    logic out_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_ff <= 1'b0;
        end else begin
            out_ff <= toggle_out_sel ? (toggle_ff ^ tc_exit) : (nxt_count == CMS_TC_VALUE);
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign armed = armed_ff;
    assign running = run_ff;
    assign count_value = count_ff;
    assign terminal_count = tc_ff;
    assign tc_toggled = toggle_ff;
    assign counter_out = out_ff;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Source edge that leaves terminal count
    sequence s_tc_exit;
        tc_ff && src_rise && !load_cmd;
    endsequence

    // Plain source edge outside terminal count
    sequence s_mid_edge;
        !tc_ff && src_rise && !load_cmd;
    endsequence

    // Ungated armed counter decrements on a source edge
    no_gate_count_a: assert property (
        (s_mid_edge and (armed_ff && gate_kind == CMS_GATE_NONE))
        |=> count_ff == $past(count_ff) - CMS_CNT_STEP)
        else $error("ungated armed counter missed a source edge");

    // Level gating drops edges while gate low
    level_block_a: assert property (
        (s_mid_edge and (gate_kind == CMS_GATE_LEVEL && !gate_lvl))
        |=> $stable(count_ff))
        else $error("level gate low but count moved");

    // Load-only single mode disarms after one exit
    once_disarm_a: assert property (
        (s_tc_exit and (!repetition_bit && !reload_source_bit && !arm_cmd))
        |=> !armed_ff)
        else $error("single terminal count did not disarm");

    // Alternating single mode disarms on second exit only
    twice_disarm_a: assert property (
        (s_tc_exit and (!repetition_bit && reload_source_bit && !arm_cmd && !disarm_cmd))
        |=> armed_ff == ($past(armed_ff) && !$past(phase_ff)))
        else $error("two-count mode disarmed at wrong exit");

    // Repetitive modes stay armed without a command
    rep_armed_a: assert property (
        (repetition_bit && armed_ff && !disarm_cmd) |=> armed_ff)
        else $error("repetitive mode disarmed itself");

    // First exit of a pair reloads from Hold
    reload_hold_a: assert property (
        (s_tc_exit and (reload_source_bit && !phase_ff))
        |=> count_ff == $past(hold_value) && phase_ff)
        else $error("first reload not from hold");

    // Terminal count counts regardless of arm state
    tc_counts_a: assert property (
        s_tc_exit |=> (toggle_ff != $past(toggle_ff)) && (count_ff ==
            (($past(reload_source_bit) && !$past(phase_ff)) ? $past(hold_value)
                                                             : $past(load_value))))
        else $error("terminal count ignored a source edge");

    // Disarmed edge counter drops gate edges
    disarmed_gate_a: assert property (
        (gate_kind == CMS_GATE_EDGE && !armed_ff && !run_ff && gate_rise)
        |=> !run_ff)
        else $error("disarmed counter took a gate edge");

    // Running lower-group edge counter holds through gate activity
    gate_ignored_a: assert property (
        (run_ff && !special_gate_bit && !cycle_done && !disarm_cmd
         && gate_kind == CMS_GATE_EDGE) |=> run_ff)
        else $error("gate disturbed a triggered count");

    // Upper edge modes stop on an inactive gate edge
    upper_stop_a: assert property (
        (run_ff && special_gate_bit && gate_fall && gate_kind == CMS_GATE_EDGE)
        |=> !run_ff)
        else $error("gate fall did not stop counting");

    // Arm command takes effect next cycle and holds two cycles idle
    arm_hold_a: assert property (
        (arm_cmd ##1 (!disarm_cmd && !auto_disarm)) |-> armed_ff [*2])
        else $error("arm command not held");

endmodule : cms_sequencer
`default_nettype wire

// [test/cms_pin_model.sv]
// Purpose: Model of the source and gate pins seen by one counter
// Assumes: Pins are active high and stay at each level for at least 2 clk
// Notes: Pins change 1 ns after the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module cms_pin_model (
    // Clock
    input wire logic clk,
    // Counter pins
    output var logic source_in,
    output var logic gate_in
);
    // ==========================================================
    // Pin drivers
    // ==========================================================
    // Both pins idle low from time zero
    initial begin
        source_in = 1'b0;
        gate_in = 1'b0;
    end

    // Source pulses: 4 clk high, 4 clk low, so the count has settled on return
    task automatic pulse_source(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1 source_in = 1'b1; // Active-going edge
            repeat (4) @(posedge clk);
            #1 source_in = 1'b0;
            repeat (3) @(posedge clk);
        end
        #2;
    endtask : pulse_source

    // Gate level change, held long enough to pass the synchroniser
    task automatic set_gate(input logic v);
        @(posedge clk);
        #1 gate_in = v;
        repeat (5) @(posedge clk);
        #2;
    endtask : set_gate
endmodule : cms_pin_model
`default_nettype wire

// [test/test_cms_sequencer.sv]
// Purpose: Self-checking bench for the counter mode sequencer
// Assumes: Pin model drives source and gate, bench issues host commands
// Notes: Expected toggle state is tracked by the bench, one flip per exit, except the exit in test_rep_f
`timescale 1ns/1ps
`default_nettype none
module test_cms_sequencer;
    import cms_pkg::*;
    // ==========================================================
    // Signals
    // ==========================================================
    logic clk, rst_n, special_gate_bit, reload_source_bit, repetition_bit;
    logic toggle_out_sel, arm_cmd, disarm_cmd, load_cmd;
    logic [CMS_GATE_W-1:0] gate_control_field;
    logic [CMS_CNT_W-1:0] load_value, hold_value, count_value;
    logic source_in, gate_in, armed, running, terminal_count, tc_toggled, counter_out;
    logic tog; // Expected toggled output
    int num_errors, checks_done;

    // Design and pin model
    cms_sequencer dut (.clk(clk), .rst_n(rst_n), .source_in(source_in), .gate_in(gate_in),
        .gate_control_field(gate_control_field), .special_gate_bit(special_gate_bit),
        .reload_source_bit(reload_source_bit), .repetition_bit(repetition_bit),
        .toggle_out_sel(toggle_out_sel), .load_value(load_value), .hold_value(hold_value),
        .arm_cmd(arm_cmd), .disarm_cmd(disarm_cmd), .load_cmd(load_cmd), .armed(armed),
        .running(running), .count_value(count_value), .terminal_count(terminal_count),
        .tc_toggled(tc_toggled), .counter_out(counter_out));
    cms_pin_model pins (.clk(clk), .source_in(source_in), .gate_in(gate_in));

    // ==========================================================
    // Helpers
    // ==========================================================
    // Compare a count value
    task automatic check_cnt(input logic [CMS_CNT_W-1:0] exp);
        checks_done++;
        if (count_value !== exp) begin
            num_errors++;
            $display("Error at %0t: count expected %h got %h", $time, exp, count_value);
        end
    endtask : check_cnt

    // Compare a one-bit flag
    task automatic check_flag(input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: flag expected %h got %h", $time, exp, got);
        end
    endtask : check_flag

    // One-cycle host command: 0 arm, 1 disarm, 2 load
    task automatic cmd(input int which);
        @(posedge clk);
        #1;
        arm_cmd = (which == 0);
        disarm_cmd = (which == 1);
        load_cmd = (which == 2);
        @(posedge clk);
        #1;
        {arm_cmd, disarm_cmd, load_cmd} = 3'b000;
        @(posedge clk);
        #2;
    endtask : cmd

    // Mode bits and reload values, then load the count
    task automatic set_mode(input logic [3:0] g, input logic sp, input logic rl,
                            input logic rp, input logic [15:0] ld, input logic [15:0] hd);
        @(posedge clk);
        #1;
        gate_control_field = g;
        {special_gate_bit, reload_source_bit, repetition_bit} = {sp, rl, rp};
        load_value = ld;
        hold_value = hd;
        cmd(2);
    endtask : set_mode

    // Run end: counts and verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // ==========================================================
    // Scenarios
    // ==========================================================
    // Ungated single shot, gate held low throughout
    task automatic test_mode_a();
        set_mode(4'h0, 1'b0, 1'b0, 1'b0, 16'h0002, 16'h0005);
        check_cnt(16'h0002);
        cmd(0);
        check_flag(1'b1, armed);
        pins.pulse_source(1);
        check_cnt(16'h0001);
        check_flag(1'b1, terminal_count);
        check_flag(1'b1, counter_out);
        pins.pulse_source(1);
        tog = ~tog;
        check_cnt(16'h0002);
        check_flag(1'b0, armed);
        check_flag(tog, tc_toggled);
        pins.pulse_source(1);
        check_cnt(16'h0002);
        $display("test_mode_a finished");
    endtask : test_mode_a

    // Level gate, lower and upper group
    task automatic test_level();
        for (int sp = 0; sp < 2; sp++) begin
            set_mode(4'h1, sp[0], 1'b0, 1'b0, 16'h0003, 16'h0005);
            cmd(0);
            pins.pulse_source(1);
            check_cnt(16'h0003);
            pins.set_gate(1'b1);
            pins.pulse_source(1);
            check_cnt(16'h0002);
            pins.set_gate(1'b0);
        end
        $display("test_level finished");
    endtask : test_level

    // Edge-triggered single shot
    task automatic test_edge_c();
        set_mode(4'h8, 1'b0, 1'b0, 1'b0, 16'h0002, 16'h0005);
        cmd(1);
        pins.set_gate(1'b1);
        pins.set_gate(1'b0);
        cmd(0);
        pins.pulse_source(1);
        check_cnt(16'h0002);
        pins.set_gate(1'b1);
        check_flag(1'b1, running);
        pins.set_gate(1'b0);
        pins.pulse_source(1);
        check_cnt(16'h0001);
        pins.pulse_source(1);
        tog = ~tog;
        check_cnt(16'h0002);
        check_flag(1'b0, armed);
        check_flag(1'b0, running);
        $display("test_edge_c finished");
    endtask : test_edge_c

    // Alternating reload, two terminal counts then disarm
    task automatic test_alt_g();
        set_mode(4'h0, 1'b0, 1'b1, 1'b0, 16'h0002, 16'h0003);
        cmd(0);
        pins.pulse_source(2);
        tog = ~tog;
        check_cnt(16'h0003);
        check_flag(1'b1, armed);
        pins.pulse_source(3);
        tog = ~tog;
        check_cnt(16'h0002);
        check_flag(1'b0, armed);
        check_flag(tog, tc_toggled);
        $display("test_alt_g finished");
    endtask : test_alt_g

    // Repetitive ungated, disarm command and disarm during terminal count
    task automatic test_rep_d();
        set_mode(4'h0, 1'b0, 1'b0, 1'b1, 16'h0002, 16'h0005);
        cmd(0);
        pins.pulse_source(4);
        tog = ~tog;
        tog = ~tog;
        check_cnt(16'h0002);
        check_flag(1'b1, armed);
        @(posedge clk);
        #1 toggle_out_sel = 1'b1;
        @(posedge clk);
        #2 check_flag(tog, counter_out);
        pins.pulse_source(1);
        cmd(1);
        check_flag(1'b0, armed);
        pins.pulse_source(1);
        tog = ~tog;
        check_cnt(16'h0002);
        check_flag(tog, counter_out);
        pins.pulse_source(1);
        check_cnt(16'h0002);
        $display("test_rep_d finished");
    endtask : test_rep_d

    // Repetitive edge mode, then upper-group stop on gate fall
    task automatic test_rep_f();
        set_mode(4'h8, 1'b0, 1'b0, 1'b1, 16'h0002, 16'h0005);
        cmd(0);
        pins.set_gate(1'b1);
        pins.set_gate(1'b0);
        pins.pulse_source(3);
        check_cnt(16'h0002);
        check_flag(1'b0, running);
        check_flag(1'b1, armed);
        pins.set_gate(1'b1);
        pins.pulse_source(1);
        check_cnt(16'h0001);
        pins.set_gate(1'b0);
        set_mode(4'h8, 1'b1, 1'b0, 1'b1, 16'h0003, 16'h0005);
        pins.set_gate(1'b1);
        pins.pulse_source(1);
        check_cnt(16'h0002);
        pins.set_gate(1'b0);
        check_flag(1'b0, running);
        pins.pulse_source(1);
        check_cnt(16'h0002);
        $display("test_rep_f finished");
    endtask : test_rep_f

    // ==========================================================
    // Clock, watchdog and main sequence
    // ==========================================================
    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Cut a hang short
    initial begin
        #50000;
        num_errors++;
        summarize();
    end

    // Reset held 3 edges; synchronous reset clears the pin synchronisers
    initial begin
        {rst_n, special_gate_bit, reload_source_bit, repetition_bit} = 4'h0;
        {toggle_out_sel, arm_cmd, disarm_cmd, load_cmd} = 4'h0;
        gate_control_field = 4'h0;
        load_value = 16'h0000;
        hold_value = 16'h0000;
        {tog, num_errors, checks_done} = '0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        #2 check_flag(1'b0, armed);
        check_cnt(16'h0000);
        test_mode_a();
        test_level();
        test_edge_c();
        test_alt_g();
        test_rep_d();
        test_rep_f();
        summarize();
    end
endmodule : test_cms_sequencer
`default_nettype wire
